/* design/video_pixel_defs.svh */
/*
 Constants of the video pixel pipeline: scan counter layout,
 decode points, shifter and FIFO sizes, timing figures.
 Assumes inclusion by bare name from the design files.
*/
`ifndef VIDEO_PIXEL_DEFS_SVH
`define VIDEO_PIXEL_DEFS_SVH

// Scan counter: prescale bits below the video address
`define VP_PRE_W 2
`define VP_ADDR_W 14
`define VP_LINE_LSB 6
`define VP_IRQ4_BIT 11

// Decode points on line and column
`define VP_LINE_240 8'hF0
`define VP_VSYNC_LO 8'hF8
`define VP_VSYNC_HI 8'hFB
`define VP_HBLANK_LO 8'h02
`define VP_HBLANK_HI 8'h3D
`define VP_HSYNC_LO 8'h3E
`define VP_HSYNC_HI 8'h3F

// Load word, pixels per load, FIFO depth
`define VP_LOAD_W 24
`define VP_CODE_W 4
`define VP_PIX_PER_LOAD 3'h6
`define VP_FIFO_DEPTH 8

// Palette geometry
`define VP_PAL_AW 4
`define VP_PAL_DW 8

// Timing: system clock and load period
`define VP_CLK_NS 50
`define VP_LOAD_PERIOD_NS 1000
`define VP_LOAD_CYC (`VP_LOAD_PERIOD_NS / `VP_CLK_NS)

`endif

/* design/video_pixel_pkg.sv */
/*
 Types of the video pixel pipeline.
 Assumes the constants header is on the include path.
*/
`include "video_pixel_defs.svh"

package video_pixel_pkg;
   // Pixel shifter states
   typedef enum logic {SH_IDLE, SH_RUN} shift_state_e;
   typedef logic [`VP_ADDR_W-1:0] scan_addr_t;
   typedef logic [`VP_LOAD_W-1:0] load_word_t;
endpackage

/* design/load_stream_if.sv */
/*
 Valid/ready stream carrying captured load words.
 Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none

interface load_stream_if #(
   parameter int W = 24
);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

/* design/load_fifo.sv */
/*
 Load word FIFO, width and depth as parameters.
 Assumes a power-of-two depth and one clock.
*/
`timescale 1ns/1ps
`default_nettype none

module load_fifo #(
   parameter int W = 24,
   parameter int DEPTH = 8
) (
   input wire logic clk_sys,
   input wire logic rst,
   load_stream_if.snk wr,
   load_stream_if.src rd
);
   localparam int AW = $clog2(DEPTH);

   // Pointer wrap bit needs a power-of-two depth
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("load_fifo depth must be a power of two");
   end

   logic [W-1:0] mem [DEPTH];
   logic [AW:0] wp;
   logic [AW:0] rp;

   // Full when indices match but wrap bits differ
   wire full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
   wire empty = (wp == rp);
   wire push = wr.valid && !full;
   wire pop = rd.ready && !empty;

   assign wr.ready = !full;
   assign rd.valid = !empty;
   assign rd.data = mem[rp[AW-1:0]];

   // Storage, no reset needed
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wp[AW-1:0]] <= wr.data;
      end
   end

   // Pointers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wp <= '0;
         rp <= '0;
      end else begin
         wp <= push ? wp + 1'b1 : wp;
         rp <= pop ? rp + 1'b1 : rp;
      end
   end
endmodule

`default_nettype wire

/* design/palette_ram.sv */
/*
 Colour palette: 16 words of 8 bits, one write port and
 one combinational read port.
 Assumes the caller multiplexes the address.
*/
`timescale 1ns/1ps
`default_nettype none
`include "video_pixel_defs.svh"

module palette_ram (
   input wire logic clk_sys,
   input wire logic we,
   input wire logic [`VP_PAL_AW-1:0] addr,
   input wire logic [`VP_PAL_DW-1:0] wdata,
   output logic [`VP_PAL_DW-1:0] rdata
);
   logic [`VP_PAL_DW-1:0] mem [2**`VP_PAL_AW];

   // Contents undefined until software loads them
   always_ff @(posedge clk_sys) begin
      if (we) begin
         mem[addr] <= wdata;
      end
   end

   assign rdata = mem[addr];
endmodule

`default_nettype wire

/* design/video_pixel_pipeline.sv */
/*
 Video pixel pipeline: clocked reset, scan address counter,
 load capture into a FIFO, pixel shifter, palette lookup,
 colour drive, sync and blanking, count read, interrupts.
 Assumes raw reset, E, 4 MHz, inverted 6 MHz, load strobe
 and bank data are asynchronous pins that clk_sys samples
 several times per period; processor strobes come from
 logic on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
`include "video_pixel_defs.svh"

// Contract
// R1: Load is taken only on a 4 MHz edge while the load strobe is low.
// R2: Each inverted 6 MHz rising edge shifts out one 4-bit code.
// R3: Order per load: two bank 1 codes, two bank 2, two bank 3.
// R4: Loads recur each microsecond; six codes drain before the next load.
// R5: Each code addresses a 16 by 8 palette that sets the colour.
// R6: Palette write selects processor address bits and stores processor data.
// R7: Palette word splits into red 3, green 3, blue 2 bits.
// R8: Horizontal and vertical sync decoded from the scan address.
// R9: Horizontal blanking decoded from scan address at left and right edges.
// R10: Count read select places high scan address bits on the read data.
// R11: Scan line 240 is decoded and raised as an interrupt.
// R12: Scan address bit 11 gives a 4 ms periodic interrupt.
// R13: Processor may only read the count and only write the palette.
// R14: Clocked reset rises on the first E rising edge after raw reset.
// R15: Load strobe captures all three banks after every video access.
// R16: Scan counter held while clocked reset low, counts 4 MHz after.
// R17: Upper nibble of each bank byte is shown first, lower second.
// R18: Blanking forces red, green and blue to zero.
module video_pixel_pipeline
   import video_pixel_pkg::*;
#(
   parameter int DEPTH = `VP_FIFO_DEPTH
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic raw_reset_n,
   input wire logic e_clk,
   input wire logic clk_4m,
   input wire logic pix_clk_n,
   input wire logic shift_load_n,
   input wire logic [7:0] bank1_data,
   input wire logic [7:0] bank2_data,
   input wire logic [7:0] bank3_data,
   input wire logic palette_write_select_n,
   input wire logic vcount_read_select_n,
   input wire logic cpu_rnw,
   input wire logic [3:0] cpu_addr,
   input wire logic [7:0] cpu_wdata,
   output logic [7:0] cpu_rdata,
   output logic clocked_reset_n,
   output scan_addr_t video_addr,
   output logic load_ready,
   output logic [2:0] red,
   output logic [2:0] green,
   output logic [1:0] blue,
   output logic hsync,
   output logic vsync,
   output logic blank,
   output logic irq_count240,
   output logic irq_4ms
);

   // Inclusive range test shared by the decoders
   function automatic logic in_range(
      input logic [7:0] v,
      input logic [7:0] lo,
      input logic [7:0] hi
   );
      in_range = (v >= lo) && (v <= hi);
   endfunction

   // Pin synchronisers, a third stage only for edge detect
   logic [3:0] pin_s1;
   logic [3:0] pin_s2;
   logic [3:0] pin_s3;
   logic load_s1;
   logic load_s2;
   load_word_t bank_s1;
   load_word_t bank_s2;
   wire [3:0] pin_raw = {raw_reset_n, e_clk, clk_4m, pix_clk_n};

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pin_s1 <= 4'h0;
         pin_s2 <= 4'h0;
         pin_s3 <= 4'h0;
         load_s1 <= 1'b1;
         load_s2 <= 1'b1;
      end else begin
         pin_s1 <= pin_raw;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         load_s1 <= shift_load_n;
         load_s2 <= load_s1;
      end
   end

   // Bank data only matters when a load is taken
   always_ff @(posedge clk_sys) begin
      bank_s1 <= {bank1_data, bank2_data, bank3_data};
      bank_s2 <= bank_s1;
   end

   wire raw_ok = pin_s2[3];
   wire e_rise = pin_s2[2] && !pin_s3[2];
   wire c4_rise = pin_s2[1] && !pin_s3[1];
   wire pix_rise = pin_s2[0] && !pin_s3[0];

   // Clocked reset: drops with raw reset, rises on an E edge
   wire next_clocked_reset_n = !raw_ok ? 1'b0 :
      (e_rise ? 1'b1 : clocked_reset_n); // [R14]

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         clocked_reset_n <= 1'b0;
      end else begin
         clocked_reset_n <= next_clocked_reset_n;
      end
   end

   // Scan counter: four 4 MHz edges per video address
   logic [`VP_PRE_W+`VP_ADDR_W-1:0] scan;
   wire [`VP_PRE_W+`VP_ADDR_W-1:0] next_scan = !clocked_reset_n ? '0 :
      (c4_rise ? scan + 1'b1 : scan); // [R16]

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         scan <= '0;
      end else begin
         scan <= next_scan;
      end
   end

   assign video_addr = scan[`VP_PRE_W +: `VP_ADDR_W];

   // Line and column views of the scan address
   wire [7:0] line = video_addr[`VP_ADDR_W-1:`VP_LINE_LSB];
   wire [7:0] hcol = {2'b00, video_addr[`VP_LINE_LSB-1:0]};

   // Sync, blanking and interrupt decode
   wire next_hsync = in_range(hcol, `VP_HSYNC_LO, `VP_HSYNC_HI); // [R8]
   wire next_vsync = in_range(line, `VP_VSYNC_LO, `VP_VSYNC_HI); // [R8]
   wire hblank = !in_range(hcol, `VP_HBLANK_LO, `VP_HBLANK_HI); // [R9]
   wire next_blank = hblank || (line >= `VP_LINE_240);
   wire next_irq240 = (line == `VP_LINE_240); // [R11]
   wire next_irq4 = video_addr[`VP_IRQ4_BIT]; // [R12]

   // Registered so the monitor sees clean edges
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         hsync <= 1'b0;
         vsync <= 1'b0;
         irq_count240 <= 1'b0;
         irq_4ms <= 1'b0;
      end else begin
         hsync <= next_hsync;
         vsync <= next_vsync;
         irq_count240 <= next_irq240;
         irq_4ms <= next_irq4;
      end
   end

   // Load capture: one word per low period of the strobe
   logic load_armed;
   load_stream_if #(.W(`VP_LOAD_W)) load_bus ();
   load_stream_if #(.W(`VP_LOAD_W)) pop_bus ();

   wire load_take = c4_rise && !load_s2 && load_armed
      && clocked_reset_n; // [R1] [R15]
   assign load_bus.valid = load_take;
   assign load_bus.data = bank_s2;
   assign load_ready = load_bus.ready;

   // Rearm only after the strobe has gone high again
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         load_armed <= 1'b1;
      end else begin
         load_armed <= load_s2 ? 1'b1 : (load_take ? 1'b0 : load_armed);
      end
   end

   // FIFO absorbs jitter between load and pixel edges
   load_fifo #(
      .W(`VP_LOAD_W),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .rst(rst),
      .wr(load_bus),
      .rd(pop_bus)
   );

   // Pixel shifter
   shift_state_e state;
   load_word_t shreg;
   logic [2:0] left;
   logic [3:0] pixel_code;

   wire pix_step = pix_rise && (state == SH_RUN) && clocked_reset_n; // [R2]
   wire last_step = pix_step && (left == 3'h1);
   // A new word is taken only once the old one is spent
   assign pop_bus.ready = (state == SH_IDLE) || last_step; // [R4]
   wire pop = pop_bus.valid && pop_bus.ready;

   shift_state_e next_state;
   assign next_state = pop ? SH_RUN : (last_step ? SH_IDLE : state);

   // Bank 1 sits on top, upper nibble leaves first
   wire [`VP_LOAD_W-1:0] next_shreg = pop ? pop_bus.data :
      (pix_step ? {shreg[`VP_LOAD_W-5:0], 4'h0} : shreg); // [R3] [R17]
   wire [2:0] next_left = pop ? `VP_PIX_PER_LOAD :
      (pix_step ? left - 3'h1 : left);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state <= SH_IDLE;
         shreg <= '0;
         left <= 3'h0;
      end else begin
         state <= next_state;
         shreg <= next_shreg;
         left <= next_left;
      end
   end

   // Code presented to the palette mux
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pixel_code <= 4'h0;
      end else if (pix_step) begin
         pixel_code <= shreg[`VP_LOAD_W-1 -: `VP_CODE_W]; // [R2]
      end
   end

   // Page 0 style grant: write palette, read count only
   wire pal_wr = !palette_write_select_n && !cpu_rnw; // [R13]
   wire vc_rd = !vcount_read_select_n && cpu_rnw; // [R13]

   // Processor address wins the palette mux while writing
   wire [3:0] pal_addr = pal_wr ? cpu_addr : pixel_code; // [R6]
   wire [7:0] pal_rdata;

   palette_ram u_palette (
      .clk_sys(clk_sys),
      .we(pal_wr),
      .addr(pal_addr),
      .wdata(cpu_wdata),
      .rdata(pal_rdata)
   );

   // Colour register; a write shows its entry, as the mux does
   logic [7:0] colour;
   wire [7:0] next_colour = next_blank ? 8'h00 : pal_rdata; // [R5] [R18]

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         colour <= 8'h00;
         blank <= 1'b1;
      end else begin
         colour <= next_colour;
         blank <= next_blank;
      end
   end

   assign red = colour[7:5]; // [R7]
   assign green = colour[4:2]; // [R7]
   assign blue = colour[1:0]; // [R7]

   // Count read: zero when not selected, so the bus can be ORed
   wire [7:0] next_rdata = vc_rd ? line : 8'h00; // [R10]

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cpu_rdata <= 8'h00;
      end else begin
         cpu_rdata <= next_rdata;
      end
   end

   // Checks
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   property p_cr_rise;
      $rose(clocked_reset_n) |-> $past(e_rise) && $past(raw_ok);
   endproperty
   a_cr_rise: assert property (p_cr_rise) // [R14]
      else $error("Clocked reset rose without an E edge");

   property p_cr_drop;
      !raw_ok |=> !clocked_reset_n;
   endproperty
   a_cr_drop: assert property (p_cr_drop) // [R14]
      else $error("Clocked reset stayed high under raw reset");

   property p_scan_hold;
      !clocked_reset_n |=> scan == '0;
   endproperty
   a_scan_hold: assert property (p_scan_hold) // [R16]
      else $error("Scan counter moved while held");

   property p_scan_step;
      clocked_reset_n && c4_rise |=> scan == $past(scan) + 1'b1;
   endproperty
   a_scan_step: assert property (p_scan_step) // [R16]
      else $error("Scan counter missed a 4 MHz edge");

   property p_one_load;
      load_bus.valid |=> !load_bus.valid [*3];
   endproperty
   a_one_load: assert property (p_one_load) // [R1]
      else $error("Load strobe captured twice");

   sequence s_pop;
      pop_bus.valid && pop_bus.ready;
   endsequence

   property p_pop_take;
      s_pop |=> shreg == $past(pop_bus.data) && left == `VP_PIX_PER_LOAD;
   endproperty
   a_pop_take: assert property (p_pop_take) // [R15]
      else $error("Shifter did not take the popped word");

   sequence s_mid_step;
      pix_step && left != 3'h1;
   endsequence

   property p_shift;
      s_mid_step |=> shreg == {$past(shreg[19:0]), 4'h0};
   endproperty
   a_shift: assert property (p_shift) // [R3]
      else $error("Shifter order broken");

   property p_code;
      pix_step |=> pixel_code == $past(shreg[23:20]);
   endproperty
   a_code: assert property (p_code) // [R17]
      else $error("Wrong nibble presented");

   property p_left;
      state == SH_RUN |-> left inside {[3'h1:3'h6]};
   endproperty
   a_left: assert property (p_left) // [R4]
      else $error("Pixel count out of range");

   property p_colour;
      !$past(next_blank) |-> {red, green, blue} == $past(pal_rdata);
   endproperty
   a_colour: assert property (p_colour) // [R5]
      else $error("Colour does not follow palette");

   property p_blank;
      blank |-> {red, green, blue} == 8'h00;
   endproperty
   a_blank: assert property (p_blank) // [R18]
      else $error("Colour shown during blanking");

   property p_pal_write;
      pal_wr ##1 pal_wr && $stable(cpu_addr) |-> pal_rdata == $past(cpu_wdata);
   endproperty
   a_pal_write: assert property (p_pal_write) // [R6]
      else $error("Palette write not stored");

   property p_vcount;
      vc_rd |=> cpu_rdata == $past(line);
   endproperty
   a_vcount: assert property (p_vcount) // [R10]
      else $error("Count read returned wrong line");

   property p_irq240;
      line == `VP_LINE_240 |=> irq_count240;
   endproperty
   a_irq240: assert property (p_irq240) // [R11]
      else $error("Line 240 interrupt missing");

   property p_irq4;
      $changed(video_addr[`VP_IRQ4_BIT]) |=> $changed(irq_4ms);
   endproperty
   a_irq4: assert property (p_irq4) // [R12]
      else $error("Address bit 11 not passed on");

   property p_hblank;
      !in_range(hcol, `VP_HBLANK_LO, `VP_HBLANK_HI) |=> blank;
   endproperty
   a_hblank: assert property (p_hblank) // [R9]
      else $error("Edge columns not blanked");

   property p_hsync;
      hsync |-> $past(in_range(hcol, `VP_HSYNC_LO, `VP_HSYNC_HI));
   endproperty
   a_hsync: assert property (p_hsync) // [R8]
      else $error("Horizontal sync outside its columns");

endmodule

`default_nettype wire

/* tb/colour_monitor.sv */
/*
 Colour monitor model: rebuilds the colour word from the guns,
 counts line syncs and counts light seen during blanking.
 Assumes all video lines are registers on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

module colour_monitor (
   input wire logic clk_sys,
   input wire logic [2:0] red,
   input wire logic [2:0] green,
   input wire logic [1:0] blue,
   input wire logic hsync,
   input wire logic blank,
   output logic [7:0] colour,
   output int lines,
   output int lit_in_blank
);
   logic hsync_d = 1'b0;
   logic blank_d = 1'b0;

   // Guns recombined, red on top
   assign colour = {red, green, blue};

   // Line count and dark check; settled blank only, the guns may trail by a cycle
   initial begin
      lines = 0;
      lit_in_blank = 0;
   end
   always @(posedge clk_sys) begin
      hsync_d <= hsync;
      blank_d <= blank;
      if (hsync === 1'b1 && hsync_d === 1'b0) lines <= lines + 1;
      if (blank === 1'b1 && blank_d === 1'b1 && colour !== 8'h00) lit_in_blank <= lit_in_blank + 1;
   end
endmodule

`default_nettype wire

/* tb/video_pixel_pipeline_tb.sv */
/*
 Self-checking bench of the video pixel pipeline.
 Assumes pin clocks driven slowly, several clk_sys per half period.
*/
`timescale 1ns/1ps
`default_nettype none
`include "video_pixel_defs.svh"

module video_pixel_pipeline_tb
   import video_pixel_pkg::*;
;
   localparam int DEPTH = `VP_FIFO_DEPTH;
   logic clk_sys = 1'b0, rst = 1'b1, raw_reset_n = 1'b0, e_clk = 1'b0, clk_4m = 1'b0;
   logic pix_clk_n = 1'b0, shift_load_n = 1'b1, cpu_rnw = 1'b1;
   logic palette_write_select_n = 1'b1, vcount_read_select_n = 1'b1;
   logic [7:0] bank1_data = 8'h00, bank2_data = 8'h00, bank3_data = 8'h00, cpu_wdata = 8'h00;
   logic [3:0] cpu_addr = 4'h0;
   logic [7:0] cpu_rdata, colour;
   logic clocked_reset_n, load_ready, hsync, vsync, blank, irq_count240, irq_4ms;
   logic [2:0] red, green;
   logic [1:0] blue;
   scan_addr_t video_addr;
   int num_errors = 0, n_compared = 0, rises = 0, lines_exp = 0, lines, lit_in_blank;
   logic [7:0] pal [16];
   logic [23:0] words [$];

   video_pixel_pipeline #(.DEPTH(DEPTH)) i_video_pixel_pipeline (
      .clk_sys(clk_sys), .rst(rst), .raw_reset_n(raw_reset_n), .e_clk(e_clk),
      .clk_4m(clk_4m), .pix_clk_n(pix_clk_n), .shift_load_n(shift_load_n),
      .bank1_data(bank1_data), .bank2_data(bank2_data), .bank3_data(bank3_data),
      .palette_write_select_n(palette_write_select_n), .vcount_read_select_n(vcount_read_select_n),
      .cpu_rnw(cpu_rnw), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
      .clocked_reset_n(clocked_reset_n), .video_addr(video_addr), .load_ready(load_ready),
      .red(red), .green(green), .blue(blue), .hsync(hsync), .vsync(vsync), .blank(blank),
      .irq_count240(irq_count240), .irq_4ms(irq_4ms)
   );

   colour_monitor i_colour_monitor (
      .clk_sys(clk_sys), .red(red), .green(green), .blue(blue), .hsync(hsync),
      .blank(blank), .colour(colour), .lines(lines), .lit_in_blank(lit_in_blank)
   );

   // 20 MHz system clock
   always #25 clk_sys = ~clk_sys;

   task chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task give_verdict;
      if (num_errors == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   // One 4 MHz rise, then the scan decode judged from our own count
   task rise4(input int h);
      scan_addr_t a;
      logic [7:0] col, line;
      logic hs;
      clk_4m = 1'b1;
      cyc(h);
      clk_4m = 1'b0;
      cyc(h);
      rises++;
      a = scan_addr_t'(rises >> `VP_PRE_W);
      col = {2'b00, a[5:0]};
      line = a[13:6];
      hs = col >= `VP_HSYNC_LO && col <= `VP_HSYNC_HI;
      if (hs && col == `VP_HSYNC_LO && rises % 4 == 0) lines_exp++;
      chk(video_addr, a);
      chk({hsync, vsync, blank, irq_count240, irq_4ms}, {hs, line >= `VP_VSYNC_LO && line <= `VP_VSYNC_HI,
         col < `VP_HBLANK_LO || col > `VP_HBLANK_HI || line >= `VP_LINE_240,
         line == `VP_LINE_240, a[`VP_IRQ4_BIT]});
   endtask

   // Strobe held low across one 4 MHz rise
   task load(input logic [23:0] w, input logic keep);
      {bank1_data, bank2_data, bank3_data} = w;
      shift_load_n = 1'b0;
      cyc(3);
      rise4(4);
      shift_load_n = 1'b1;
      cyc(2);
      if (keep) words.push_back(w);
   endtask

   task reset_seq;
      cyc(12);
      rst = 1'b0;
      cyc(1);
      chk({clocked_reset_n, blank, red, green, blue}, {1'b0, 1'b1, 8'h00});
      raw_reset_n = 1'b1;
      cyc(6);
      chk(clocked_reset_n, 1'b0);
      clk_4m = 1'b1;
      cyc(3);
      clk_4m = 1'b0;
      cyc(3);
      chk(video_addr, 14'h0000);
      e_clk = 1'b1;
      cyc(6);
      chk(clocked_reset_n, 1'b1);
      chk(video_addr, 14'h0000);
   endtask

   // Back-to-back writes, then a read-direction attempt on entry 5
   task palette_seq;
      palette_write_select_n = 1'b0;
      cpu_rnw = 1'b0;
      // Same entry twice running, so the store check sees a steady address
      cpu_addr = 4'h0;
      cpu_wdata = 8'hC3;
      cyc(2);
      for (int i = 0; i < 16; i++) begin
         cpu_addr = 4'(i);
         cpu_wdata = {4'(i), ~4'(i)};
         pal[i] = cpu_wdata;
         cyc(1);
      end
      cpu_rnw = 1'b1;
      cpu_addr = 4'h5;
      cpu_wdata = 8'h00;
      cyc(1);
      palette_write_select_n = 1'b1;
      cyc(1);
   endtask

   // Fill until refused, lose one load, drain with six codes per word
   task fifo_seq;
      int n;
      logic [23:0] w;
      n = 0;
      while (load_ready === 1'b1 && n < 12) begin
         load(24'h13_579B + 24'(n) * 24'h21_0F3C, 1'b1);
         n++;
      end
      chk(16'(n), 16'(DEPTH + 1));
      load(24'h0F_0F0F, 1'b0);
      while (words.size() > 0) begin
         w = words.pop_front();
         for (int k = 5; k >= 0; k--) begin
            pix_clk_n = 1'b1;
            cyc(6);
            chk(colour, pal[w[k*4 +: 4]]);
            pix_clk_n = 1'b0;
            cyc(4);
         end
      end
      chk(load_ready, 1'b1);
   endtask

   // Wrong direction answers zero, a true read gives the line
   task read_seq;
      vcount_read_select_n = 1'b0;
      cpu_rnw = 1'b0;
      cyc(1);
      chk(cpu_rdata, 8'h00);
      cpu_rnw = 1'b1;
      cyc(1);
      chk(cpu_rdata, 8'(rises >> (`VP_PRE_W + `VP_LINE_LSB)));
      vcount_read_select_n = 1'b1;
      cyc(2);
      chk(cpu_rdata, 8'h00);
   endtask

   // Raw reset mid-run: drops at once, rises only on a fresh E edge
   task rearm_seq;
      raw_reset_n = 1'b0;
      cyc(4);
      chk(clocked_reset_n, 1'b0);
      chk(video_addr, 14'h0000);
      raw_reset_n = 1'b1;
      cyc(4);
      chk(clocked_reset_n, 1'b0);
      e_clk = 1'b0;
      cyc(3);
      e_clk = 1'b1;
      cyc(6);
      chk(clocked_reset_n, 1'b1);
   endtask

   // Main sequence; the long scan run passes address bit 11
   initial begin
      reset_seq;
      palette_seq;
      while (rises < 12) rise4(3);
      fifo_seq;
      while (rises < 8256) rise4(3);
      read_seq;
      chk(16'(lines), 16'(lines_exp));
      chk(16'(lit_in_blank), 16'h0000);
      rearm_seq;
      give_verdict;
   end

   // Watchdog, about twice the expected run
   initial begin
      #4_500_000;
      num_errors++;
      give_verdict;
   end
endmodule

`default_nettype wire
